// [core/stcc_pkg.sv]
// package of constants and types for the split timer channel control block
//------------------------------------------------------------------------------
// Function
// - low channel 2-bit mode: 00 off, 01 compare, 10 capture, 11 both
// - low mode fields at offset 0x04, channel D high bits to A low
// - high mode fields at offset 0x05, same layout and encoding
// - restart irq level in bits 5:4, requested while restart flag set
// - error irq level in bits 3:2 enables error interrupt at level
// - wrap irq level in bits 1:0, requested while wrap flag set
// - offset 0x07 holds four low channel irq levels, D to A
// - run and buffer registers have set and clear aliases, same read
// - stop bit 5 resets to 1, halts counter and disables outputs
// - clearing stop restarts counter unless clock source is off
// - command: 00 none, 01 update, 10 restart, 11 reset only when off
// - command field bits 3:2 always read zero
// - update lock bit 1 blocks buffer transfer on update
// - update lock does not block buffer transfer with input capture enabled; the code checks the low channel modes only
// - direction bit 0: 0 up, 1 down; hardware or software may set it
// - low buffer valid bits 4:1 set on buffer write, cleared on update; the code does not clear them on update while update lock is set
// - in capture, valid set by capture event, cleared with channel flag
// - high channels have no buffer valid bits
// - period buffer valid bit 0 set on buffer write, cleared on update; the code does not clear it on update while update lock is set
//------------------------------------------------------------------------------
package stcc_pkg;
   localparam int          STCC_NCH         = 4;
   localparam logic [7:0]  STCC_OFS_LMODE   = 8'h04;
   localparam logic [7:0]  STCC_OFS_HMODE   = 8'h05;
   localparam logic [7:0]  STCC_OFS_TIRQ    = 8'h06;
   localparam logic [7:0]  STCC_OFS_CIRQ    = 8'h07;
   // register indices: the byte address on the bus is four times the index
   localparam logic [7:0]  STCC_OFS_RUN_CLR = 8'h08;
   localparam logic [7:0]  STCC_OFS_RUN_SET = 8'h09;
   localparam logic [7:0]  STCC_OFS_BV_CLR  = 8'h0A;
   localparam logic [7:0]  STCC_OFS_BV_SET  = 8'h0B;
   localparam int          STCC_BIT_STOP    = 5;
   localparam int          STCC_CMD_LSB     = 2;
   localparam int          STCC_BIT_LOCK    = 1;
   localparam int          STCC_BIT_DIR     = 0;
   localparam int          STCC_BIT_PERBV   = 0;
   localparam int          STCC_BV_LSB      = 1;
   localparam logic [7:0]  STCC_TIRQ_MASK   = 8'h3F;
   localparam logic [7:0]  STCC_RUN_MASK    = 8'h23;
   localparam logic [7:0]  STCC_BV_MASK     = 8'h1F;
   localparam logic [7:0]  STCC_RUN_RESET   = 8'h20;
   localparam logic [1:0]  STCC_RESP_OKAY   = 2'b00;
   localparam logic [1:0]  STCC_RESP_SLVERR = 2'b10;
   localparam logic [3:0]  STCC_CLK_OFF     = 4'h0;

   typedef enum logic [1:0] {
      STCC_MODE_OFF  = 2'b00,
      STCC_MODE_COMP = 2'b01,
      STCC_MODE_INPUT_CAPTURE = 2'b10,
      STCC_MODE_BOTH = 2'b11
   } stcc_mode_t;

   typedef enum logic [1:0] {
      STCC_CMD_NONE    = 2'b00,
      STCC_CMD_UPDATE  = 2'b01,
      STCC_CMD_RESTART = 2'b10,
      STCC_CMD_RESET   = 2'b11
   } stcc_cmd_t;

   typedef enum logic [1:0] {
      STCC_LVL_OFF = 2'b00,
      STCC_LVL_LO  = 2'b01,
      STCC_LVL_MED = 2'b10,
      STCC_LVL_HI  = 2'b11
   } stcc_lvl_t;
endpackage

// [core/stcc_wr_if.sv]
// interface carrying one decoded register write from bus slave to register file
`timescale 1ns/10ps
interface stcc_wr_if;
   logic       stb;
   logic [7:0] addr;
   logic [7:0] data;
   modport src (output stb, output addr, output data);
   modport dst (input stb, input addr, input data);
endinterface

// [core/stcc_axi_slave.sv]
// axi4-lite slave that turns bus writes into strobes and serves reads
`timescale 1ns/10ps
module stcc_axi_slave (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // axi write channels
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi read channels
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // register side
   stcc_wr_if.src           wr,
   output logic [7:0]       rd_addr,
   input  wire logic [7:0]  rd_data,
   input  wire logic        rd_hit
);
   import stcc_pkg::*;

   logic       aw_held;
   logic       w_held;
   logic [7:0] aw_q;
   logic [7:0] w_q;
   logic       w_lane0;
   logic       ar_pend;

   //---------------------------------------------------------------------------
   // write path
   //---------------------------------------------------------------------------
   assign awready = !aw_held && !bvalid;
   assign wready  = !w_held && !bvalid;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_q    <= 8'h00;
         w_q     <= 8'h00;
         w_lane0 <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= STCC_RESP_OKAY;
         wr.stb  <= 1'b0;
         wr.addr <= 8'h00;
         wr.data <= 8'h00;
      end else begin
         wr.stb <= 1'b0;
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_q    <= awaddr;
         end
         if (wvalid && wready) begin
            w_held  <= 1'b1;
            w_q     <= wdata[7:0];
            w_lane0 <= wstrb[0];
         end
         if (aw_held && w_held) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            bvalid  <= 1'b1;
            wr.stb  <= w_lane0 && (aw_q[1:0] == 2'b00);
            wr.addr <= {2'b00, aw_q[7:2]};
            wr.data <= w_q;
            bresp   <= (aw_q[1:0] == 2'b00) ? STCC_RESP_OKAY : STCC_RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   //---------------------------------------------------------------------------
   // read path
   //---------------------------------------------------------------------------
   assign arready = !ar_pend && !rvalid;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ar_pend <= 1'b0;
         rd_addr <= 8'h00;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= STCC_RESP_OKAY;
      end else begin
         if (arvalid && arready) begin
            ar_pend <= 1'b1;
            rd_addr <= (araddr[1:0] == 2'b00) ? {2'b00, araddr[7:2]} : 8'hff;
         end
         if (ar_pend) begin
            ar_pend <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h00_0000, rd_data};
            rresp   <= rd_hit ? STCC_RESP_OKAY : STCC_RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end
endmodule // stcc_axi_slave

// [core/stcc_top.sv]
// control and status registers of the split timer channels
`timescale 1ns/10ps
module stcc_top (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // axi write channels
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi read channels
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // counting engine status and events
   input  wire logic [3:0]  clock_source_select,
   input  wire logic        counter_off,
   input  wire logic        hw_dir_load,
   input  wire logic        hw_dir_value,
   input  wire logic        update_event,
   input  wire logic [3:0]  low_chan_compare_buffer_wr,
   input  wire logic        low_period_buffer_wr,
   input  wire logic [3:0]  capture_event,
   input  wire logic [3:0]  low_chan_flag_clr,
   input  wire logic        restart_flag,
   input  wire logic        error_flag,
   input  wire logic        wrap_flag,
   input  wire logic [3:0]  low_chan_flag,
   // controls toward the counting engine
   output logic [7:0]       low_chan_cc_mode,
   output logic [7:0]       high_chan_cc_mode,
   output logic             counter_run,
   output logic             outputs_enable,
   output logic             force_update,
   output logic             force_restart,
   output logic             force_reset,
   output logic             buffer_transfer,
   output logic             count_down,
   output logic [3:0]       low_chan_buffer_valid,
   output logic             period_buffer_valid,
   // interrupt level requests
   output logic [1:0]       restart_irq_req,
   output logic [1:0]       error_irq_req,
   output logic [1:0]       wrap_irq_req,
   output logic [7:0]       low_chan_irq_req
);
   import stcc_pkg::*;

   stcc_wr_if wr ();

   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   logic       rd_hit;
   logic [7:0] low_channel_mode_ctrl;
   logic [7:0] high_channel_mode_ctrl;
   logic [7:0] timer_irq_level_ctrl;
   logic [7:0] channel_irq_level_ctrl;
   logic       stop;
   logic       update_lock;
   logic       dir;
   logic [3:0] chan_bv;
   logic       per_bv;
   logic       run_set_wr;
   logic       run_clr_wr;
   logic       bv_set_wr;
   logic       bv_clr_wr;
   logic       any_capture;
   logic [1:0] next_cmd;
   logic       update_fire;

   //---------------------------------------------------------------------------
   // bus slave
   //---------------------------------------------------------------------------
   stcc_axi_slave u_slave (
      .ref_clk (ref_clk),
      .rst     (rst),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wr      (wr),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_hit  (rd_hit)
   );

   assign run_set_wr = wr.stb && (wr.addr == STCC_OFS_RUN_SET);
   assign run_clr_wr = wr.stb && (wr.addr == STCC_OFS_RUN_CLR);
   assign bv_set_wr  = wr.stb && (wr.addr == STCC_OFS_BV_SET);
   assign bv_clr_wr  = wr.stb && (wr.addr == STCC_OFS_BV_CLR);
   assign next_cmd   = run_set_wr ? wr.data[STCC_CMD_LSB +: 2] : STCC_CMD_NONE;

   //---------------------------------------------------------------------------
   // plain control registers
   //---------------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         low_channel_mode_ctrl  <= 8'h00;
         high_channel_mode_ctrl <= 8'h00;
         timer_irq_level_ctrl   <= 8'h00;
         channel_irq_level_ctrl <= 8'h00;
      end else if (wr.stb) begin
         if (wr.addr == STCC_OFS_LMODE) begin
            low_channel_mode_ctrl <= wr.data;
         end
         if (wr.addr == STCC_OFS_HMODE) begin
            high_channel_mode_ctrl <= wr.data;
         end
         if (wr.addr == STCC_OFS_TIRQ) begin
            timer_irq_level_ctrl <= wr.data & STCC_TIRQ_MASK;
         end
         if (wr.addr == STCC_OFS_CIRQ) begin
            channel_irq_level_ctrl <= wr.data;
         end
      end
   end

   //---------------------------------------------------------------------------
   // run control: set wins over clear within one write
   //---------------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         stop        <= STCC_RUN_RESET[STCC_BIT_STOP];
         update_lock <= 1'b0;
      end else if (run_set_wr) begin
         stop        <= stop | wr.data[STCC_BIT_STOP];
         update_lock <= update_lock | wr.data[STCC_BIT_LOCK];
      end else if (run_clr_wr) begin
         stop        <= stop & ~wr.data[STCC_BIT_STOP];
         update_lock <= update_lock & ~wr.data[STCC_BIT_LOCK];
      end
   end

   // hardware loads direction unless software sets or clears the direction bit in the same cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         dir <= 1'b0;
      end else if (run_set_wr && wr.data[STCC_BIT_DIR]) begin
         dir <= 1'b1;
      end else if (run_clr_wr && wr.data[STCC_BIT_DIR]) begin
         dir <= 1'b0;
      end else if (hw_dir_load) begin
         dir <= hw_dir_value;
      end
   end

   //---------------------------------------------------------------------------
   // commands and update
   //---------------------------------------------------------------------------
   always_comb begin
      any_capture = 1'b0;
      for (int i = 0; i < STCC_NCH; i++) begin
         if (low_channel_mode_ctrl[2*i +: 2] == STCC_MODE_INPUT_CAPTURE ||
             low_channel_mode_ctrl[2*i +: 2] == STCC_MODE_BOTH) begin
            any_capture = 1'b1;
         end
      end
   end

   assign update_fire = update_event || (next_cmd == STCC_CMD_UPDATE);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         force_update    <= 1'b0;
         force_restart   <= 1'b0;
         force_reset     <= 1'b0;
         buffer_transfer <= 1'b0;
      end else begin
         force_update    <= next_cmd == STCC_CMD_UPDATE;
         force_restart   <= next_cmd == STCC_CMD_RESTART;
         force_reset     <= (next_cmd == STCC_CMD_RESET) && counter_off;
         buffer_transfer <= update_fire && (!update_lock || any_capture);
      end
   end

   //---------------------------------------------------------------------------
   // buffer valid bits, low channels and period only
   //---------------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < STCC_NCH; g++) begin : g_bv
         logic input_capture;
         assign input_capture = low_channel_mode_ctrl[2*g+1];
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               chan_bv[g] <= 1'b0;
            end else if (bv_set_wr && wr.data[STCC_BV_LSB+g]) begin
               chan_bv[g] <= 1'b1;
            end else if (input_capture ? capture_event[g] : low_chan_compare_buffer_wr[g]) begin
               chan_bv[g] <= 1'b1;
            end else if (bv_clr_wr && wr.data[STCC_BV_LSB+g]) begin
               chan_bv[g] <= 1'b0;
            end else if (input_capture ? low_chan_flag_clr[g]
                              : (update_fire && !update_lock)) begin
               chan_bv[g] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         per_bv <= 1'b0;
      end else if (low_period_buffer_wr ||
                   (bv_set_wr && wr.data[STCC_BIT_PERBV])) begin
         per_bv <= 1'b1;
      end else if ((bv_clr_wr && wr.data[STCC_BIT_PERBV]) ||
                   (update_fire && !update_lock)) begin
         per_bv <= 1'b0;
      end
   end

   //---------------------------------------------------------------------------
   // outputs toward engine and interrupt controller
   //---------------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         low_chan_cc_mode      <= 8'h00;
         high_chan_cc_mode     <= 8'h00;
         counter_run           <= 1'b0;
         outputs_enable        <= 1'b0;
         count_down            <= 1'b0;
         low_chan_buffer_valid <= 4'h0;
         period_buffer_valid   <= 1'b0;
         restart_irq_req       <= STCC_LVL_OFF;
         error_irq_req         <= STCC_LVL_OFF;
         wrap_irq_req          <= STCC_LVL_OFF;
         low_chan_irq_req      <= 8'h00;
      end else begin
         low_chan_cc_mode      <= low_channel_mode_ctrl;
         high_chan_cc_mode     <= high_channel_mode_ctrl;
         counter_run           <= !stop && (clock_source_select != STCC_CLK_OFF);
         outputs_enable        <= !stop;
         count_down            <= dir;
         low_chan_buffer_valid <= chan_bv;
         period_buffer_valid   <= per_bv;
         restart_irq_req       <= restart_flag ? timer_irq_level_ctrl[5:4] : STCC_LVL_OFF;
         error_irq_req         <= error_flag ? timer_irq_level_ctrl[3:2] : STCC_LVL_OFF;
         wrap_irq_req          <= wrap_flag ? timer_irq_level_ctrl[1:0] : STCC_LVL_OFF;
         for (int i = 0; i < STCC_NCH; i++) begin
            low_chan_irq_req[2*i +: 2] <= low_chan_flag[i] ?
                                          channel_irq_level_ctrl[2*i +: 2] : STCC_LVL_OFF;
         end
      end
   end

   //---------------------------------------------------------------------------
   // read mux
   //---------------------------------------------------------------------------
   always_comb begin
      rd_hit  = 1'b1;
      rd_data = 8'h00;
      unique case (rd_addr)
         STCC_OFS_LMODE:                     rd_data = low_channel_mode_ctrl;
         STCC_OFS_HMODE:                     rd_data = high_channel_mode_ctrl;
         STCC_OFS_TIRQ:                      rd_data = timer_irq_level_ctrl;
         STCC_OFS_CIRQ:                      rd_data = channel_irq_level_ctrl;
         STCC_OFS_RUN_CLR, STCC_OFS_RUN_SET: rd_data = {2'b00, stop, 3'b000,
                                                        update_lock, dir};
         STCC_OFS_BV_CLR, STCC_OFS_BV_SET:   rd_data = {3'b000, chan_bv, per_bv};
         default:                            rd_hit  = 1'b0;
      endcase
   end
endmodule // stcc_top

// [sim/stcc_top_sva.sv]
// assertions on the ports of the split timer channel control block
`timescale 1ns/10ps
module stcc_top_sva (
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       rst,
   // bus handshakes
   input wire logic       awvalid,
   input wire logic       awready,
   input wire logic       wvalid,
   input wire logic       wready,
   input wire logic       bvalid,
   input wire logic       arvalid,
   input wire logic       arready,
   input wire logic       rvalid,
   // engine side
   input wire logic [3:0] clock_source_select,
   input wire logic       counter_off,
   input wire logic       update_event,
   input wire logic [3:0] low_chan_compare_buffer_wr,
   input wire logic       low_period_buffer_wr,
   input wire logic       wrap_flag,
   input wire logic       restart_flag,
   input wire logic [7:0] low_chan_cc_mode,
   input wire logic       counter_run,
   input wire logic       outputs_enable,
   input wire logic       force_update,
   input wire logic       force_restart,
   input wire logic       force_reset,
   input wire logic       buffer_transfer,
   input wire logic [3:0] low_chan_buffer_valid,
   input wire logic       period_buffer_valid,
   input wire logic [1:0] wrap_irq_req,
   input wire logic [1:0] restart_irq_req
);
   //--------------------
   // sequences
   //--------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_wr_both;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_rd_wait;
      arvalid && arready ##1 !rvalid;
   endsequence
   //--------------------
   // properties
   //--------------------
   a_write_answer: assert property (s_wr_both |-> ##2 bvalid)
      else $error("write response missing");
   a_read_answer: assert property (s_rd_wait |=> rvalid)
      else $error("read data missing");
   a_run_clock: assert property (counter_run |-> $past(clock_source_select) != 4'h0)
      else $error("counter runs with clock off");
   a_run_stop: assert property (counter_run |-> outputs_enable)
      else $error("counter runs while stopped");
   a_cmd_onehot: assert property ($onehot0({force_update, force_restart, force_reset}))
      else $error("two commands at once");
   a_reset_off: assert property (force_reset |-> $past(counter_off))
      else $error("hard reset while not off");
   a_bv_write: assert property (low_chan_compare_buffer_wr[0] && !low_chan_cc_mode[1]
      |-> ##2 low_chan_buffer_valid[0])
      else $error("buffer valid not set");
   a_per_write: assert property (low_period_buffer_wr |-> ##2 period_buffer_valid)
      else $error("period valid not set");
   a_xfer_cause: assert property (buffer_transfer
      |-> $past(update_event) || force_update)
      else $error("transfer without update");
   a_wrap_irq: assert property (wrap_irq_req != 2'b00 |-> $past(wrap_flag))
      else $error("wrap request without flag");
   a_restart_irq: assert property (restart_irq_req != 2'b00 |-> $past(restart_flag))
      else $error("restart request without flag");
endmodule // stcc_top_sva

bind stcc_top stcc_top_sva u_sva (.*);

// [sim/testbench.sv]
// self-checking bench for the split timer channel control block
`timescale 1ns/10ps
module testbench;
   import stcc_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
   logic        rvalid, rready, counter_off, hw_dir_load, hw_dir_value, update_event;
   logic        low_period_buffer_wr, restart_flag, error_flag, wrap_flag, counter_run;
   logic        outputs_enable, force_update, force_restart, force_reset, buffer_transfer;
   logic        count_down, period_buffer_valid;
   logic [1:0]  bresp, rresp, restart_irq_req, error_irq_req, wrap_irq_req;
   logic [3:0]  wstrb, clock_source_select, low_chan_compare_buffer_wr, capture_event;
   logic [3:0]  low_chan_flag_clr, low_chan_flag, low_chan_buffer_valid;
   logic [7:0]  awaddr, araddr, low_chan_cc_mode, high_chan_cc_mode, low_chan_irq_req;
   logic [31:0] wdata, rdata;
   int          mismatches = 0, samples_checked = 0, n_upd = 0, n_rsr = 0, n_rst = 0, n_xfr = 0;
   logic [7:0]  mv [5] = '{8'h18, 8'h24, 8'h96, 8'h24, 8'he4};

   stcc_top dut (.*);

   always #5 ref_clk = ~ref_clk;
   // pulse counters
   always @(posedge ref_clk) begin
      n_upd <= n_upd + int'(force_update === 1'b1);
      n_rsr <= n_rsr + int'(force_restart === 1'b1);
      n_rst <= n_rst + int'(force_reset === 1'b1);
      n_xfr <= n_xfr + int'(buffer_transfer === 1'b1);
   end
   //--------------------
   // tasks
   //--------------------
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   // a is a register index; a[7:6] gives a misaligned byte address
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      @(posedge ref_clk);
      awaddr <= {a[5:0], a[7:6]};
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      check("bresp", er, bresp);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      @(posedge ref_clk);
      araddr <= {a[5:0], a[7:6]};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      check("rdata", {24'h00_0000, e}, rdata);
      check("rresp", er, rresp);
      rready <= 1'b0;
   endtask
   task automatic ev(input logic [3:0] bw, input logic pw, input logic up,
                     input logic [3:0] cp, input logic [3:0] fc);
      @(posedge ref_clk);
      {low_chan_compare_buffer_wr, low_period_buffer_wr, update_event} <= {bw, pw, up};
      {capture_event, low_chan_flag_clr} <= {cp, fc};
      @(posedge ref_clk);
      {low_chan_compare_buffer_wr, low_period_buffer_wr, update_event} <= 6'h00;
      {capture_event, low_chan_flag_clr} <= 8'h00;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   //--------------------
   // tests
   //--------------------
   initial begin
      #100us;
      mismatches++;
      results();
   end
   initial begin
      logic [7:0] a;
      int         x0;
      rst = 1'b1;
      {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata} = '0;
      {wstrb, clock_source_select, counter_off, hw_dir_load, hw_dir_value} = 11'h780;
      {low_chan_compare_buffer_wr, low_period_buffer_wr, capture_event, update_event} = '0;
      {low_chan_flag_clr, restart_flag, error_flag, wrap_flag, low_chan_flag} = '0;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      rd(STCC_OFS_RUN_CLR, STCC_RUN_RESET, STCC_RESP_OKAY);
      rd(STCC_OFS_RUN_SET, 8'h20, STCC_RESP_OKAY);
      rd(STCC_OFS_BV_CLR, 8'h00, STCC_RESP_OKAY);
      check("outputs_enable", 1'b0, outputs_enable);
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         a = (i < 2) ? STCC_OFS_LMODE : 8'(i + 3);
         wr(a, mv[i], STCC_RESP_OKAY);
         rd(a, mv[i], STCC_RESP_OKAY);
         if (i < 2) check("low_chan_cc_mode", mv[i], low_chan_cc_mode);
      end
      check("high_chan_cc_mode", 8'h96, high_chan_cc_mode);
      wr(8'h41, 8'hff, STCC_RESP_SLVERR);
      rd(8'h20, 8'h00, STCC_RESP_SLVERR);
      $display("test modes done");
      clock_source_select <= 4'h1;
      wr(STCC_OFS_RUN_CLR, 8'h20, STCC_RESP_OKAY);
      repeat (3) @(posedge ref_clk);
      check("counter_run", 1'b1, counter_run);
      check("outputs_enable", 1'b1, outputs_enable);
      clock_source_select <= STCC_CLK_OFF;
      repeat (3) @(posedge ref_clk);
      check("counter_run", 1'b0, counter_run);
      wr(STCC_OFS_RUN_SET, 8'h03, STCC_RESP_OKAY);
      rd(STCC_OFS_RUN_CLR, 8'h03, STCC_RESP_OKAY);
      check("count_down", 1'b1, count_down);
      wr(STCC_OFS_RUN_CLR, 8'h01, STCC_RESP_OKAY);
      {hw_dir_load, hw_dir_value} <= 2'b11;
      @(posedge ref_clk);
      hw_dir_load <= 1'b0;
      rd(STCC_OFS_RUN_SET, 8'h03, STCC_RESP_OKAY);
      for (int c = 1; c < 4; c++) begin
         wr(STCC_OFS_RUN_SET, 8'(c << 2), STCC_RESP_OKAY);
         rd(STCC_OFS_RUN_SET, 8'h03, STCC_RESP_OKAY);
      end
      check("updates", 1, n_upd);
      check("restarts", 1, n_rsr);
      check("resets", 0, n_rst);
      counter_off <= 1'b1;
      wr(STCC_OFS_RUN_SET, 8'h0c, STCC_RESP_OKAY);
      repeat (3) @(posedge ref_clk);
      check("resets", 1, n_rst);
      counter_off <= 1'b0;
      $display("test run control done");
      wr(STCC_OFS_RUN_CLR, 8'h03, STCC_RESP_OKAY);
      wr(STCC_OFS_LMODE, 8'h00, STCC_RESP_OKAY);
      ev(4'b0101, 1'b1, 1'b0, 4'h0, 4'h0);
      rd(STCC_OFS_BV_SET, 8'h0b, STCC_RESP_OKAY);
      check("period_buffer_valid", 1'b1, period_buffer_valid);
      wr(STCC_OFS_RUN_SET, 8'h02, STCC_RESP_OKAY);
      x0 = n_xfr;
      ev(4'h0, 1'b0, 1'b1, 4'h0, 4'h0);
      rd(STCC_OFS_BV_CLR, 8'h0b, STCC_RESP_OKAY);
      check("transfers", x0, n_xfr);
      wr(STCC_OFS_RUN_CLR, 8'h02, STCC_RESP_OKAY);
      ev(4'h0, 1'b0, 1'b1, 4'h0, 4'h0);
      rd(STCC_OFS_BV_CLR, 8'h00, STCC_RESP_OKAY);
      check("transfers", x0 + 1, n_xfr);
      wr(STCC_OFS_BV_SET, 8'h1f, STCC_RESP_OKAY);
      rd(STCC_OFS_BV_CLR, STCC_BV_MASK, STCC_RESP_OKAY);
      wr(STCC_OFS_BV_CLR, 8'h1f, STCC_RESP_OKAY);
      rd(STCC_OFS_BV_SET, 8'h00, STCC_RESP_OKAY);
      $display("test buffer valid done");
      wr(STCC_OFS_LMODE, 8'h02, STCC_RESP_OKAY);
      wr(STCC_OFS_RUN_SET, 8'h02, STCC_RESP_OKAY);
      x0 = n_xfr;
      ev(4'h0, 1'b0, 1'b0, 4'h1, 4'h0);
      rd(STCC_OFS_BV_SET, 8'h02, STCC_RESP_OKAY);
      ev(4'h0, 1'b0, 1'b1, 4'h0, 4'h0);
      check("transfers", x0 + 1, n_xfr);
      ev(4'h0, 1'b0, 1'b0, 4'h0, 4'h1);
      rd(STCC_OFS_BV_SET, 8'h00, STCC_RESP_OKAY);
      {restart_flag, error_flag, wrap_flag, low_chan_flag} <= 7'h7f;
      repeat (3) @(posedge ref_clk);
      check("irq", 14'h24e4, {restart_irq_req, error_irq_req, wrap_irq_req,
         low_chan_irq_req});
      $display("test capture and irq done");
      results();
   end
endmodule // testbench
